/* File: tb.sv */
// self-checking bench for the watchdog unit
`timescale 1ns/1ps
`include "wdt_consts.svh"

`define CHK(g, e) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("unexpected t=%0t got %h exp %h", $time, (g), (e)); \
    end \
end

module tb;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic        clock = 1'b0;         // 100 MHz
    logic        rst = 1'b1;           // held 12 cycles
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_d;
    logic        pready, pslverr, irq_req, wd_reset, err_d, hit;
    logic        wd_restart, irq_ack, global_irq_en;
    logic        fuse = 1'b0, bo = 1'b0, pin = 1'b0;
    logic        kick_en = 1'b1, ack_en = 1'b0, gie_want = 1'b1;
    logic [3:0]  ack_delay = 4'h0;     // prompt service first
    int          fails = 0, samples_checked = 0, rst_seen = 0, rs;

    always #5 clock = ~clock;

    // short base count keeps every time-out near 3200 clocks
    wdt_top #(.BASE_TICKS(4)) u_wdt_top (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wd_restart(wd_restart), .irq_ack(irq_ack),
        .global_irq_en(global_irq_en), .always_on_fuse(fuse),
        .brownout_rst(bo), .pin_rst(pin), .irq_req(irq_req),
        .wd_reset(wd_reset));

    wdt_cpu_model u_wdt_cpu_model (
        .clock(clock), .rst(rst), .irq_req(irq_req), .kick_en(kick_en),
        .ack_en(ack_en), .gie_want(gie_want), .ack_delay(ack_delay),
        .wd_restart(wd_restart), .irq_ack(irq_ack),
        .global_irq_en(global_irq_en));

    // count reset pulse cycles as seen at the edge
    always @(posedge clock) begin
        if (wd_reset === 1'b1) rst_seen++;
    end

    // ****************************************************************
    // bus tasks
    // ****************************************************************
    // one transfer; caller follows with xfer or idle in the same step
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] wd);
        int n;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= wd;
        psel    <= 1'b1;
        penable <= 1'b0;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        rd_d  = prdata;
        err_d = pslverr;
    endtask

    task automatic idle();
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h0, d});
        idle();
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic ee);
        xfer(1'b0, a, 32'h0);
        idle();
        `CHK(rd_d, e)
        `CHK(err_d, ee)
    endtask

    // opening write then settings write back to back
    task automatic timed(input logic [7:0] v);
        xfer(1'b1, `WDT_CTRL_OFF, {24'h0, v | 8'h18});
        xfer(1'b1, `WDT_CTRL_OFF, {24'h0, v});
        idle();
    endtask

    // bounded wait for the reset pulse (1) or the request (0)
    task automatic wait_ev(input logic r, input int lim);
        hit = 1'b0;
        for (int i = 0; i < lim && hit !== 1'b1; i++) begin
            @(posedge clock);
            hit = r ? wd_reset : irq_req;
        end
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // a hang counts as a mismatch; tests need about 30k cycles
    initial begin
        repeat (100000) @(posedge clock);
        fails++;
        complete_run();
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        // reset values, unmapped word, power-on flag
        rd(`WDT_CTRL_OFF, 32'h00, 1'b0);
        rd(`WDT_CAUSE_OFF, 32'h01, 1'b0);
        rd(12'h100, 32'h00, 1'b1);
        wr(`WDT_CAUSE_OFF, 8'h00);
        rd(`WDT_CAUSE_OFF, 32'h00, 1'b0);
        bo <= 1'b1;
        @(posedge clock);
        bo  <= 1'b0;
        pin <= 1'b1;
        @(posedge clock);
        pin <= 1'b0;
        @(posedge clock);
        rd(`WDT_CAUSE_OFF, 32'h06, 1'b0);
        wr(`WDT_CAUSE_OFF, 8'h04);
        rd(`WDT_CAUSE_OFF, 32'h04, 1'b0);
        wr(`WDT_CAUSE_OFF, 8'h00);
        rd(`WDT_CAUSE_OFF, 32'h00, 1'b0);
        $display("test cause flags done");
        // protected settings
        wr(`WDT_CTRL_OFF, 8'h08);
        rd(`WDT_CTRL_OFF, 32'h08, 1'b0);
        wr(`WDT_CTRL_OFF, 8'h21);
        rd(`WDT_CTRL_OFF, 32'h08, 1'b0);
        timed(8'h29);
        rd(`WDT_CTRL_OFF, 32'h29, 1'b0);
        xfer(1'b1, `WDT_CTRL_OFF, 32'h39);
        xfer(1'b0, `WDT_CTRL_OFF, 32'h0);
        idle();
        `CHK(rd_d, 32'h39)
        repeat (6) @(posedge clock);
        wr(`WDT_CTRL_OFF, 8'h00);
        rd(`WDT_CTRL_OFF, 32'h29, 1'b0);
        timed(8'h00);
        rd(`WDT_CTRL_OFF, 32'h00, 1'b0);
        $display("test timed change done");
        // reset mode with and without restarts
        wr(`WDT_CTRL_OFF, 8'h08);
        rs = rst_seen;
        repeat (8000) @(posedge clock);
        `CHK(rst_seen, rs)
        kick_en <= 1'b0;
        wait_ev(1'b1, 5000);
        `CHK(hit, 1'b1)
        @(posedge clock);
        `CHK(wd_reset, 1'b0)
        kick_en <= 1'b1;
        rd(`WDT_CAUSE_OFF, 32'h08, 1'b0);
        rd(`WDT_CTRL_OFF, 32'h08, 1'b0);
        timed(8'h00);
        rd(`WDT_CTRL_OFF, 32'h08, 1'b0);
        wr(`WDT_CAUSE_OFF, 8'h00);
        rd(`WDT_CAUSE_OFF, 32'h00, 1'b0);
        timed(8'h00);
        rd(`WDT_CTRL_OFF, 32'h00, 1'b0);
        $display("test reset mode done");
        // interrupt mode and global enable gating
        kick_en  <= 1'b0;
        gie_want <= 1'b0;
        rs = rst_seen;
        wr(`WDT_CTRL_OFF, 8'h40);
        repeat (4000) @(posedge clock);
        rd(`WDT_CTRL_OFF, 32'hc0, 1'b0);
        `CHK(irq_req, 1'b0)
        gie_want <= 1'b1;
        repeat (4) @(posedge clock);
        `CHK(irq_req, 1'b1)
        wr(`WDT_CTRL_OFF, 8'hc0);
        rd(`WDT_CTRL_OFF, 32'h40, 1'b0);
        `CHK(irq_req, 1'b0)
        ack_en <= 1'b1;
        wait_ev(1'b0, 5000);
        `CHK(hit, 1'b1)
        repeat (8) @(posedge clock);
        rd(`WDT_CTRL_OFF, 32'h40, 1'b0);
        `CHK(rst_seen, rs)
        $display("test interrupt mode done");
        // combined mode, slow service then none
        ack_delay <= 4'h5;
        wr(`WDT_CTRL_OFF, 8'h48);
        wait_ev(1'b0, 5000);
        repeat (12) @(posedge clock);
        rd(`WDT_CTRL_OFF, 32'h08, 1'b0);
        ack_en <= 1'b0;
        wr(`WDT_CTRL_OFF, 8'h48);
        wait_ev(1'b0, 5000);
        `CHK(hit, 1'b1)
        wait_ev(1'b1, 5000);
        `CHK(hit, 1'b1)
        rd(`WDT_CAUSE_OFF, 32'h08, 1'b0);
        wr(`WDT_CAUSE_OFF, 8'h00);
        timed(8'h00);
        $display("test combined mode done");
        // fuse locks reset mode
        fuse <= 1'b1;
        wr(`WDT_CTRL_OFF, 8'h40);
        rd(`WDT_CTRL_OFF, 32'h08, 1'b0);
        timed(8'h00);
        rd(`WDT_CTRL_OFF, 32'h08, 1'b0);
        wait_ev(1'b1, 5000);
        `CHK(hit, 1'b1)
        $display("test fuse done");
        complete_run();
    end
endmodule

/* File: wdt_consts.svh */
// timing counts, register offsets and field positions of the watchdog
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// ****************************************************************
// clock and oscillator timing
// ****************************************************************
`define WDT_CLK_HZ      100000000
`define WDT_OSC_HZ      125000
`define WDT_OSC_DIV     (`WDT_CLK_HZ / `WDT_OSC_HZ)
`define WDT_DIV_W       10
`define WDT_BASE_TICKS  2048
`define WDT_CNT_W       27
`define WDT_WIN_CYC     3'h4

// ****************************************************************
// register byte offsets
// ****************************************************************
`define WDT_CAUSE_OFF   12'h034
`define WDT_CTRL_OFF    12'h060

// ****************************************************************
// control register fields
// ****************************************************************
`define WDT_IF_BIT      7
`define WDT_IE_BIT      6
`define WDT_P3_BIT      5
`define WDT_CE_BIT      4
`define WDT_WDE_BIT     3
`define WDT_PLO_HI      2
`define WDT_PLO_LO      0

// ****************************************************************
// reset cause register fields
// ****************************************************************
`define WDT_WD_CAUSE_FLAG_BIT    3
`define WDT_BROWNOUT_CAUSE_FLAG_BIT    2
`define WDT_PINF_BIT    1
`define WDT_POWERON_CAUSE_FLAG_BIT    0
`define WDT_CAUSE_POR   4'h1
`define WDT_CTRL_RST    8'h00

`endif

/* File: wdt_counter.sv */
// watchdog counter with prescaled limit and restart
`timescale 1ns/1ps
`include "wdt_consts.svh"

module wdt_counter
    import wdt_pkg::*;
#(
    parameter int unsigned BASE_TICKS = `WDT_BASE_TICKS
)(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic       restart,
    input  wire logic       run,
    input  wire logic [3:0] presc,
    output logic            timeout
);

    // ****************************************************************
    // counter state
    // ****************************************************************
    wdt_cnt_state_t s_r;   // registered state
    wdt_cnt_state_t s_nxt; // next state

    // limit in oscillator ticks: base shifted by the prescaler code
    function automatic logic [31:0] limit_of(input logic [3:0] p);
        limit_of = 32'(BASE_TICKS) << p; // see [RQ23]
    endfunction

    // count ticks; restart or a stopped unit holds the count at zero
    always_comb begin
        s_nxt         = s_r;
        s_nxt.timeout = 1'b0;
        if (restart || !run) begin
            s_nxt.cnt = '0; // see [RQ2]
        end else if (tick) begin
            // reaching the limit fires one pulse and starts over
            if ({5'h00, s_r.cnt} + 32'h1 >= limit_of(presc)) begin
                s_nxt.cnt     = '0;
                s_nxt.timeout = 1'b1; // see [RQ1]
            end else begin
                s_nxt.cnt = s_r.cnt + 27'h1;
            end
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign timeout = s_r.timeout;

endmodule

/* File: wdt_cpu_model.sv */
// behavioural cpu core driving restarts, vector service and global enable
`timescale 1ns/1ps

module wdt_cpu_model (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       irq_req,
    input  wire logic       kick_en,
    input  wire logic       ack_en,
    input  wire logic       gie_want,
    input  wire logic [3:0] ack_delay,
    output logic            wd_restart,
    output logic            irq_ack,
    output logic            global_irq_en
);
    // ****************************************************************
    // software loop state
    // ****************************************************************
    logic [11:0] kick_cnt;     // cycles since last restart instruction
    logic [3:0]  wait_cnt;     // service latency so far
    logic [2:0]  hold_cnt;     // quiet time after a vector, request lags

    // restart loop, vector entry and global enable bit
    always_ff @(posedge clock) begin
        if (rst) begin
            kick_cnt      <= 12'h000;
            wait_cnt      <= 4'h0;
            hold_cnt      <= 3'h0;
            wd_restart    <= 1'b0;
            irq_ack       <= 1'b0;
            global_irq_en <= 1'b0;
        end else begin
            global_irq_en <= gie_want;
            wd_restart    <= 1'b0;
            irq_ack       <= 1'b0;
            kick_cnt      <= kick_cnt + 12'h001;
            // restart well inside the shortest period used
            if (kick_en && kick_cnt >= 12'h3e7) begin
                kick_cnt   <= 12'h000;
                wd_restart <= 1'b1;
            end
            // request drops a cycle after the vector: wait it out
            if (hold_cnt != 3'h0) begin
                hold_cnt <= hold_cnt - 3'h1;
            end else if (irq_req && ack_en) begin
                if (wait_cnt >= ack_delay) begin
                    irq_ack  <= 1'b1;
                    wait_cnt <= 4'h0;
                    hold_cnt <= 3'h4;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end
        end
    end
endmodule

/* File: wdt_pkg.sv */
// types shared by the watchdog modules
package wdt_pkg;

    // ****************************************************************
    // timed-change window state
    // ****************************************************************
    typedef enum logic {
        WDT_WIN_SHUT,
        WDT_WIN_OPEN
    } wdt_win_t;

    // control fields as held in flops
    typedef struct packed {
        logic       irq_flag;
        logic       irq_en;
        logic [3:0] presc;
        logic       reset_enable_bit;
    } wdt_ctrl_t;

    // reset cause flags, bit order as read
    typedef struct packed {
        logic wd;
        logic bo;
        logic pin;
        logic po;
    } wdt_cause_t;

    // ****************************************************************
    // per-module state records
    // ****************************************************************
    typedef struct packed {
        wdt_ctrl_t   ctrl;
        wdt_cause_t  cause;
        wdt_win_t    win;
        logic [2:0]  win_cnt;
        logic        irq_req;
        logic        rst_pulse;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } wdt_top_state_t;

    typedef struct packed {
        logic [26:0] cnt;
        logic        timeout;
    } wdt_cnt_state_t;

    typedef struct packed {
        logic [9:0] cnt;
        logic       tick;
    } wdt_div_state_t;

endpackage

/* File: wdt_tick_div.sv */
// oscillator-rate tick generator for the watchdog
`timescale 1ns/1ps
`include "wdt_consts.svh"

module wdt_tick_div
    import wdt_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    output logic      tick
);

    // ****************************************************************
    // divider state
    // ****************************************************************
    wdt_div_state_t s_r;   // registered state
    wdt_div_state_t s_nxt; // next state

    localparam logic [9:0] DIV_LAST = 10'(`WDT_OSC_DIV - 1);

    // one tick per oscillator period, free running
    always_comb begin
        s_nxt      = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.cnt == DIV_LAST) begin // see [RQ1]
            s_nxt.cnt  = 10'h000;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 10'h001;
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;

endmodule

/* File: wdt_top.sv */
// watchdog unit with timed-change protection and reset cause flags
`timescale 1ns/1ps
`include "wdt_consts.svh"

// What this block does
// [RQ1] count oscillator ticks, time out at limit
// [RQ2] restart instruction clears counter to zero
// [RQ3] interrupt mode raises request, wakes any sleep
// [RQ4] mode decoded from reset and irq enables
// [RQ5] vector taken clears flag, and enable only in combined mode
// [RQ6] unserviced second time-out gives system reset
// [RQ7] software re-arms irq enable after interrupt
// [RQ8] fuse forces reset enable one, irq zero
// [RQ9] open change with change and reset enable
// [RQ10] new settings accepted within four cycles only
// [RQ11] outside window prescaler and clear ignored
// [RQ12] software restarts before shortening the period
// [RQ13] init clears cause flag and reset enable
// [RQ14] watchdog cause flag set, cleared by zero
// [RQ15] brown-out cause flag set, cleared by zero
// [RQ16] pin cause flag set, cleared by zero
// [RQ17] power-on flag cleared only by software
// [RQ18] irq flag cleared by vector or one
// [RQ19] request needs global and local enables
// [RQ20] control register bit layout, resets zero
// [RQ21] change enable self-clears after four cycles
// [RQ22] watchdog cause flag holds reset enable
// [RQ23] limit is 2048 ticks times two^code
// [RQ24] reset pulse lasts one clock cycle
// [RQ25] restart and settings meet ticks cleanly
module wdt_top
    import wdt_pkg::*;
#(
    parameter int unsigned BASE_TICKS = `WDT_BASE_TICKS
)(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        wd_restart,
    input  wire logic        irq_ack,
    input  wire logic        global_irq_en,
    input  wire logic        always_on_fuse,
    input  wire logic        brownout_rst,
    input  wire logic        pin_rst,
    output logic             irq_req,
    output logic             wd_reset
);

    // ****************************************************************
    // state and internal wires
    // ****************************************************************
    wdt_top_state_t s_r;     // registered state
    wdt_top_state_t s_nxt;   // next state
    logic           tick;    // one pulse per oscillator period
    logic           timeout; // counter reached its limit
    logic           run;     // unit not stopped
    logic           restart; // counter back to zero
    logic           sys_evt; // any system reset seen this cycle
    logic           acc_wr;  // write completes this edge
    logic           setup;   // setup phase, answer next cycle
    logic           wr_ctrl; // control register written
    logic           wr_cause;// cause register written
    logic           open_w;  // change window open

    // address match against one register's byte offset
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        hit = (a == off);
    endfunction

    // read view of the control register
    function automatic logic [7:0] ctrl_view(input wdt_ctrl_t c,
                                             input logic ce);
        ctrl_view = {c.irq_flag, c.irq_en, c.presc[3], ce,
                     c.reset_enable_bit, c.presc[2:0]}; // see [RQ20]
    endfunction

    // ****************************************************************
    // oscillator tick and counter
    // ****************************************************************
    // one clock: the tick is an enable, so restart and settings are
    // taken on a clean edge with no crossing hazard
    wdt_tick_div u_div (
        .clock (clock),
        .rst   (rst),
        .tick  (tick)
    );

    wdt_counter #(
        .BASE_TICKS (BASE_TICKS)
    ) u_cnt (
        .clock   (clock),
        .rst     (rst),
        .tick    (tick),
        .restart (restart),
        .run     (run),
        .presc   (s_r.ctrl.presc),
        .timeout (timeout)
    );

    // stopped only with both enables clear
    assign run     = s_r.ctrl.reset_enable_bit | s_r.ctrl.irq_en; // see [RQ4]
    // system resets also start the count over
    assign sys_evt = brownout_rst | pin_rst | s_r.rst_pulse;
    assign restart = wd_restart | sys_evt; // see [RQ2] [RQ25]

    // ****************************************************************
    // bus decode
    // ****************************************************************
    assign setup    = psel & ~penable & ~s_r.pready;
    assign acc_wr   = psel & penable & s_r.pready & pwrite;
    assign wr_ctrl  = acc_wr & hit(paddr, `WDT_CTRL_OFF);
    assign wr_cause = acc_wr & hit(paddr, `WDT_CAUSE_OFF);
    assign open_w   = (s_r.win == WDT_WIN_OPEN);

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        s_nxt           = s_r;
        s_nxt.rst_pulse = 1'b0;
        s_nxt.pready    = 1'b0;
        s_nxt.pslverr   = 1'b0;

        // window countdown, closes on its own
        if (open_w) begin
            if (s_r.win_cnt == 3'h1) begin
                s_nxt.win     = WDT_WIN_SHUT; // see [RQ21]
                s_nxt.win_cnt = 3'h0;
            end else begin
                s_nxt.win_cnt = s_r.win_cnt - 3'h1;
            end
        end

        // control write
        if (wr_ctrl) begin
            s_nxt.ctrl.irq_en = pwdata[`WDT_IE_BIT];
            // flag is write-one-to-clear
            if (pwdata[`WDT_IF_BIT]) begin
                s_nxt.ctrl.irq_flag = 1'b0; // see [RQ18]
            end
            if (open_w && !pwdata[`WDT_CE_BIT]) begin
                // second step inside the window
                s_nxt.ctrl.reset_enable_bit   = pwdata[`WDT_WDE_BIT]; // see [RQ10]
                s_nxt.ctrl.presc = {pwdata[`WDT_P3_BIT],
                                    pwdata[`WDT_PLO_HI:`WDT_PLO_LO]};
                s_nxt.win        = WDT_WIN_SHUT;
                s_nxt.win_cnt    = 3'h0;
            end else if (pwdata[`WDT_WDE_BIT]) begin
                // setting reset enable is never guarded
                s_nxt.ctrl.reset_enable_bit = 1'b1; // see [RQ11]
            end
            // opening write needs both bits set together
            if (pwdata[`WDT_CE_BIT] && pwdata[`WDT_WDE_BIT]) begin
                s_nxt.win     = WDT_WIN_OPEN; // see [RQ9]
                s_nxt.win_cnt = `WDT_WIN_CYC;
            end
        end

        // vector taken: combined mode drops to reset mode
        if (irq_ack) begin
            s_nxt.ctrl.irq_flag = 1'b0; // see [RQ18]
            if (s_r.ctrl.reset_enable_bit) begin
                s_nxt.ctrl.irq_en = 1'b0; // see [RQ5]
            end
        end

        // any system reset returns control to its reset value
        if (sys_evt) begin
            s_nxt.ctrl    = wdt_ctrl_t'(7'(`WDT_CTRL_RST)); // see [RQ20]
            s_nxt.win     = WDT_WIN_SHUT;
            s_nxt.win_cnt = 3'h0;
        end

        // time-out action by mode; set wins over any clear above
        if (timeout) begin
            if (s_r.ctrl.irq_en) begin
                if (s_r.ctrl.reset_enable_bit && s_r.ctrl.irq_flag && !irq_ack) begin
                    s_nxt.rst_pulse = 1'b1; // see [RQ6]
                end else begin
                    s_nxt.ctrl.irq_flag = 1'b1; // see [RQ3] [RQ4]
                end
            end else if (s_r.ctrl.reset_enable_bit) begin
                s_nxt.rst_pulse = 1'b1; // see [RQ4] [RQ24]
            end
        end

        // cause flags: write zero clears, events set
        if (wr_cause) begin
            s_nxt.cause = s_r.cause &
                wdt_cause_t'(pwdata[`WDT_WD_CAUSE_FLAG_BIT:`WDT_POWERON_CAUSE_FLAG_BIT]);
        end
        if (s_r.rst_pulse) begin
            s_nxt.cause.wd = 1'b1; // see [RQ14]
        end
        if (brownout_rst) begin
            s_nxt.cause.bo = 1'b1; // see [RQ15]
        end
        if (pin_rst) begin
            s_nxt.cause.pin = 1'b1; // see [RQ16]
        end

        // fuse locks reset mode whatever was written
        if (always_on_fuse) begin
            s_nxt.ctrl.irq_en = 1'b0; // see [RQ8]
            s_nxt.ctrl.reset_enable_bit    = 1'b1; // see [RQ8]
        end
        // cause flag holds reset enable so a loop keeps resetting
        if (s_nxt.cause.wd) begin
            s_nxt.ctrl.reset_enable_bit = 1'b1; // see [RQ22]
        end

        // request level, independent of any sleep state
        s_nxt.irq_req = s_nxt.ctrl.irq_en & s_nxt.ctrl.irq_flag &
                        global_irq_en; // see [RQ19] [RQ3]

        // zero-wait answer: prepared in setup, shown in access
        if (setup) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = 32'h0000_0000;
            if (hit(paddr, `WDT_CTRL_OFF)) begin
                s_nxt.prdata[7:0] = ctrl_view(s_r.ctrl, open_w);
            end else if (hit(paddr, `WDT_CAUSE_OFF)) begin
                s_nxt.prdata[3:0] = s_r.cause;
            end else begin
                s_nxt.pslverr = 1'b1; // unmapped address
            end
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    // rst is the power-on reset: it alone sets the power-on flag and
    // clears the others; only a cause-register write of zero clears the power-on flag
    always_ff @(posedge clock) begin
        if (rst) begin
            s_r       <= '0;
            s_r.cause <= wdt_cause_t'(`WDT_CAUSE_POR); // see [RQ17]
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops
    assign prdata   = s_r.prdata;
    assign pready   = s_r.pready;
    assign pslverr  = s_r.pslverr;
    assign irq_req  = s_r.irq_req;
    assign wd_reset = s_r.rst_pulse;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_pulse_one_cycle: assert property ( // see [RQ24]
        wd_reset |=> !wd_reset)
        else $error("watchdog reset pulse longer than one cycle");

    a_wd_cause_set: assert property ( // see [RQ14]
        wd_reset |=> s_r.cause.wd && s_r.ctrl.reset_enable_bit)
        else $error("watchdog cause flag not set after reset pulse");

    a_wde_held: assert property ( // see [RQ22]
        s_r.cause.wd |-> s_r.ctrl.reset_enable_bit)
        else $error("reset enable clear while cause flag set");

    a_fuse_lock: assert property ( // see [RQ8]
        always_on_fuse |=> s_r.ctrl.reset_enable_bit && !s_r.ctrl.irq_en)
        else $error("fuse did not lock reset mode");

    a_window_close: assert property ( // see [RQ21]
        (open_w && s_r.win_cnt == 3'h1 && !wr_ctrl) |=> !open_w)
        else $error("change enable not cleared after four cycles");

    a_window_len: assert property ( // see [RQ10]
        (wr_ctrl && pwdata[`WDT_CE_BIT] && pwdata[`WDT_WDE_BIT]
         && !sys_evt) |=> open_w && s_r.win_cnt == `WDT_WIN_CYC)
        else $error("change window not opened for four cycles");

    a_window_step: assert property ( // see [RQ21]
        (open_w && s_r.win_cnt != 3'h1 && !wr_ctrl && !sys_evt)
        |=> open_w && s_r.win_cnt == $past(s_r.win_cnt) - 3'h1)
        else $error("change window countdown skipped a cycle");

    a_presc_locked: assert property ( // see [RQ11]
        (wr_ctrl && !open_w && !sys_evt) |=> $stable(s_r.ctrl.presc))
        else $error("prescaler changed outside window");

    a_irq_gate: assert property ( // see [RQ19]
        irq_req |-> $past(global_irq_en) && s_r.ctrl.irq_en)
        else $error("request without both enables");

    a_ack_clear: assert property ( // see [RQ5]
        (irq_ack && s_r.ctrl.reset_enable_bit && !timeout && !wr_ctrl)
        |=> !s_r.ctrl.irq_en && !s_r.ctrl.irq_flag)
        else $error("vector did not clear enable and flag");

    a_unserviced_rst: assert property ( // see [RQ6]
        (timeout && s_r.ctrl.irq_en && s_r.ctrl.reset_enable_bit &&
         s_r.ctrl.irq_flag && !irq_ack) |=> wd_reset)
        else $error("no reset on unserviced second time-out");

    c_irq_raised: cover property (timeout ##[1:3] irq_req);
    c_timed_change: cover property (open_w ##[1:3] wr_ctrl);
    c_wd_reset: cover property (s_r.ctrl.irq_en ##[1:1000] wd_reset);

endmodule
